// >>> hw/pms_phy_mgmt_status.sv
// PHY management controller with PHY status and identification registers
`timescale 1ns/10ps
module pms_phy_mgmt_status #(
  parameter int unsigned CYCLE_CLKS = pms_pkg::MGMT_CYCLE_CLKS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_write_strobe,
  input  wire logic        reg_read_strobe,
  input  wire logic [3:0]  reg_select,
  input  wire logic [7:0]  reg_write_data,
  output logic      [7:0]  reg_read_data,
  input  wire logic        link_up_pin,
  input  wire logic        jabber_pin,
  input  wire logic        transmitting_pin,
  input  wire logic        receiving_pin,
  input  wire logic        collision_pin,
  input  wire logic        polarity_reversed_pin,
  input  wire logic        second_led_pin,
  output logic             phy_write_strobe,
  output logic      [4:0]  phy_write_address,
  output logic      [15:0] phy_write_value,
  output logic             full_duplex_mode
);
  import pms_pkg::*;

  typedef enum logic [2:0] {
    PMS_IDLE  = 3'b001,
    PMS_READ  = 3'b010,
    PMS_WRITE = 3'b100
  } pms_state_t;

  typedef struct packed {
    pms_state_t  state;
    logic        scan_enable;
    logic        single_read_request;
    logic        data_not_valid;
    logic [4:0]  phy_reg_address;
    logic [7:0]  write_data_low;
    logic [15:0] write_data_high_word;
    logic [15:0] mgmt_read_data;
    logic [15:0] cycle_count;
    logic        latched_link_up;
    logic        latched_jabber;
    logic        duplex_state;
    logic        strap_taken;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  live;
    logic [7:0]  rdata;
    logic        wstrobe;
  } pms_regs_t;

  pms_regs_t r_reg;
  pms_regs_t r_next;

  // Value of a PHY register as seen by the management engine
  function automatic logic [15:0] phy_value(input pms_regs_t s, input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      PHY_CONTROL_ONE:
        v[CTL_DUPLEX_BIT] = s.duplex_state;
      PHY_LATCHED_STATUS:
      begin
        v[LS_FDPX_BIT]   = 1'b1;
        v[LS_HDPX_BIT]   = 1'b1;
        v[LS_LINK_BIT]   = s.latched_link_up;
        v[LS_JABBER_BIT] = s.latched_jabber;
      end
      PHY_IDENT_HIGH:
        v = IDENT_HIGH_VALUE;
      PHY_IDENT_LOW:
        v = {IDENT_LOW_OUI_BITS, PART_NUMBER_VALUE, REVISION_VALUE};
      PHY_LIVE_STATUS:
      begin
        v[LV_TRANSMIT_BIT]  = s.live[0];
        v[LV_RECEIVE_BIT]   = s.live[1];
        v[LV_COLLISION_BIT] = s.live[2];
        v[LV_LINK_BIT]      = s.live[3];
        v[LV_DUPLEX_BIT]    = s.duplex_state;
        v[LV_POLARITY_BIT]  = s.live[4];
      end
      default:
        v = 16'h0000;
    endcase
    return v;
  endfunction : phy_value

  logic [5:0]  pins;
  logic        busy;
  logic        cycle_done;
  logic        latched_read;

  assign pins = {jabber_pin, polarity_reversed_pin, link_up_pin, collision_pin,
                 receiving_pin, transmitting_pin};
  assign busy = (r_reg.state != PMS_IDLE);
  assign cycle_done = (r_reg.cycle_count == 16'(CYCLE_CLKS - 1));
  // Host fetch of read data low in the last cycle of a latched-status operation also counts as reading it
  assign latched_read = reg_read_strobe && (reg_select == REG_READ_DATA_LOW)
                        && cycle_done && (r_reg.phy_reg_address == PHY_LATCHED_STATUS);

  always_comb
  begin
    r_next = r_reg;
    r_next.wstrobe = 1'b0;
    // Three-stage pin synchronisers; change accepted once stages two and three agree
    r_next.sync1 = pins;
    r_next.sync2 = r_reg.sync1;
    r_next.sync3 = r_reg.sync2;
    // Filter: a one-cycle glitch never reaches the live copy
    for (int i = 0; i < 6; i++)
    begin
      if (r_reg.sync2[i] == r_reg.sync3[i])
      begin
        r_next.live[i] = r_reg.sync3[i];
      end
    end
    // Strap caught once after reset release
    // Taken raw: the strap is static, so no synchroniser delay is spent on it
    if (!r_reg.strap_taken)
    begin
      r_next.strap_taken = 1'b1;
      r_next.duplex_state = second_led_pin;
    end
    // Latched bits; a new event wins over the clear-on-read below
    if (r_reg.phy_reg_address == PHY_LATCHED_STATUS && r_reg.state == PMS_READ && cycle_done)
    begin
      r_next.latched_link_up = r_reg.live[3];
      r_next.latched_jabber  = r_reg.live[5];
    end
    if (!r_reg.live[3])
    begin
      r_next.latched_link_up = 1'b0;
    end
    if (r_reg.live[5])
    begin
      r_next.latched_jabber = 1'b1;
    end
    // Counter runs only while busy and is left at zero for the next operation
    // Engine
    if (busy)
    begin
      r_next.cycle_count = cycle_done ? 16'h0000 : r_reg.cycle_count + 16'h0001;
    end
    unique case (r_reg.state)
      PMS_IDLE:
      begin
        // A high-byte write in this cycle wins; the pending read follows it
        if (r_reg.scan_enable || r_reg.single_read_request)
        begin
          r_next.state = PMS_READ;
          r_next.data_not_valid = 1'b1;
        end
      end
      PMS_READ:
      begin
        if (cycle_done)
        begin
          r_next.mgmt_read_data = phy_value(r_reg, r_reg.phy_reg_address);
          r_next.data_not_valid = 1'b0;
          r_next.single_read_request = 1'b0;
          // Scan keeps cycling until enable is cleared, then busy drops
          if (!r_reg.scan_enable)
          begin
            r_next.state = PMS_IDLE;
          end
        end
      end
      PMS_WRITE:
      begin
        if (cycle_done)
        begin
          r_next.state = PMS_IDLE;
          r_next.wstrobe = 1'b1;
          if (r_reg.phy_reg_address == PHY_CONTROL_ONE)
          begin
            r_next.duplex_state = r_reg.write_data_high_word[CTL_DUPLEX_BIT];
          end
        end
      end
      default:
        r_next.state = PMS_IDLE;
    endcase
    // Host register writes
    if (reg_write_strobe)
    begin
      unique case (reg_select)
        REG_MGMT_COMMAND:
        begin
          // A pending single read survives a command write until it is served
          r_next.scan_enable = reg_write_data[CMD_SCAN_BIT];
          r_next.single_read_request = reg_write_data[CMD_SINGLE_READ_BIT]
                                       | (r_reg.single_read_request && busy);
        end
        REG_PHY_REG_ADDRESS:
          r_next.phy_reg_address = reg_write_data[4:0];
        REG_WRITE_DATA_LOW:
          r_next.write_data_low = reg_write_data;
        REG_WRITE_DATA_HIGH:
        begin
          // Ignored while busy: host is not allowed to overlap a scan
          if (!busy)
          begin
            r_next.write_data_high_word = {reg_write_data, r_reg.write_data_low};
            r_next.state = PMS_WRITE;
            r_next.cycle_count = 16'h0000;
          end
        end
        default:
          ;
      endcase
    end
    // Fetching read data low in the last cycle of a latched-status operation clears the latches
    if (latched_read)
    begin
      r_next.latched_link_up = r_reg.live[3];
      r_next.latched_jabber = r_reg.live[5];
    end
    // Host register reads
    // Registered, so read data trails the selector by one cycle
    unique case (reg_select)
      REG_MGMT_COMMAND:
        r_next.rdata = {6'h00, r_reg.scan_enable, r_reg.single_read_request};
      REG_MGMT_STATUS:
        r_next.rdata = {5'h00, r_reg.data_not_valid, r_reg.scan_enable && busy,
                        busy};
      REG_PHY_REG_ADDRESS:
        r_next.rdata = {3'h0, r_reg.phy_reg_address};
      REG_WRITE_DATA_LOW:
        r_next.rdata = r_reg.write_data_low;
      REG_WRITE_DATA_HIGH:
        r_next.rdata = r_reg.write_data_high_word[15:8];
      REG_READ_DATA_LOW:
        r_next.rdata = r_reg.mgmt_read_data[7:0];
      REG_READ_DATA_HIGH:
        r_next.rdata = r_reg.mgmt_read_data[15:8];
      REG_SILICON_REVISION:
        r_next.rdata = {3'h0, SILICON_REV_VALUE};
      default:
        r_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      r_reg.state                <= PMS_IDLE;
      r_reg.scan_enable          <= MGMT_COMMAND_RESET[CMD_SCAN_BIT];
      r_reg.single_read_request  <= MGMT_COMMAND_RESET[CMD_SINGLE_READ_BIT];
      r_reg.data_not_valid       <= 1'b0;
      r_reg.phy_reg_address      <= 5'h00;
      r_reg.write_data_low       <= 8'h00;
      r_reg.write_data_high_word <= 16'h0000;
      r_reg.mgmt_read_data       <= READ_DATA_RESET;
      r_reg.cycle_count          <= 16'h0000;
      r_reg.latched_link_up      <= 1'b0;
      r_reg.latched_jabber       <= 1'b0;
      r_reg.duplex_state         <= 1'b0;
      r_reg.strap_taken          <= 1'b0;
      r_reg.sync1                <= 6'h00;
      r_reg.sync2                <= 6'h00;
      r_reg.sync3                <= 6'h00;
      r_reg.live                 <= 6'h00;
      r_reg.rdata                <= 8'h00;
      r_reg.wstrobe              <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign reg_read_data     = r_reg.rdata;
  assign phy_write_strobe  = r_reg.wstrobe;
  assign phy_write_address = r_reg.phy_reg_address;
  assign phy_write_value   = r_reg.write_data_high_word;
  assign full_duplex_mode  = r_reg.duplex_state;
endmodule : pms_phy_mgmt_status

// >>> hw/pms_pkg.sv
// Package: register map, field positions, reset values and timing for PHY management/status
package pms_pkg;
  // Register selector on the device-internal register port
  localparam logic [3:0] REG_MGMT_COMMAND       = 4'h0;
  localparam logic [3:0] REG_MGMT_STATUS        = 4'h1;
  localparam logic [3:0] REG_PHY_REG_ADDRESS    = 4'h2;
  localparam logic [3:0] REG_WRITE_DATA_LOW     = 4'h3;
  localparam logic [3:0] REG_WRITE_DATA_HIGH    = 4'h4;
  localparam logic [3:0] REG_READ_DATA_LOW      = 4'h5;
  localparam logic [3:0] REG_READ_DATA_HIGH     = 4'h6;
  localparam logic [3:0] REG_SILICON_REVISION   = 4'h7;
  // PHY register addresses
  localparam logic [4:0] PHY_CONTROL_ONE        = 5'h00;
  localparam logic [4:0] PHY_LATCHED_STATUS     = 5'h01;
  localparam logic [4:0] PHY_IDENT_HIGH         = 5'h02;
  localparam logic [4:0] PHY_IDENT_LOW          = 5'h03;
  localparam logic [4:0] PHY_LIVE_STATUS        = 5'h11;
  // Command bits
  localparam int CMD_SINGLE_READ_BIT = 0;
  localparam int CMD_SCAN_BIT        = 1;
  // Status bits
  localparam int ST_BUSY_BIT         = 0;
  localparam int ST_SCAN_BIT         = 1;
  localparam int ST_DATA_NOT_VALID_BIT       = 2;
  // Latched status bits
  localparam int LS_JABBER_BIT       = 1;
  localparam int LS_LINK_BIT         = 2;
  localparam int LS_HDPX_BIT         = 11;
  localparam int LS_FDPX_BIT         = 12;
  // Live status bits, then the control register duplex bit
  localparam int LV_POLARITY_BIT     = 5;
  localparam int LV_DUPLEX_BIT       = 9;
  localparam int LV_LINK_BIT         = 10;
  localparam int LV_COLLISION_BIT    = 11;
  localparam int LV_RECEIVE_BIT      = 12;
  localparam int LV_TRANSMIT_BIT     = 13;
  localparam int CTL_DUPLEX_BIT      = 8;
  // Identity values: arbitrary, not those of any real part
  localparam logic [15:0] IDENT_HIGH_VALUE   = 16'h1234;
  localparam logic [5:0]  IDENT_LOW_OUI_BITS = 6'h15;
  localparam logic [5:0]  PART_NUMBER_VALUE  = 6'h00;
  localparam logic [3:0]  REVISION_VALUE     = 4'h0;
  localparam logic [4:0]  SILICON_REV_VALUE  = 5'h01;
  // Reset values
  localparam logic [7:0]  MGMT_COMMAND_RESET = 8'h00;
  localparam logic [15:0] READ_DATA_RESET    = 16'h0000;
  // Management cycle time
  localparam real CLK_PERIOD_NS      = 20.0;
  localparam real MGMT_CYCLE_US      = 10.24;
  localparam int  MGMT_CYCLE_CLKS    = int'($floor(MGMT_CYCLE_US * 1000.0 / CLK_PERIOD_NS));
endpackage : pms_pkg

// >>> tb/pms_phy_model.sv
// Far-side PHY stand-in: status line drivers and control register store
`timescale 1ns/10ps
module pms_phy_model (
  input  logic        sys_clk,
  input  logic [5:0]  pin_cmd,
  input  logic        wr_strobe,
  input  logic [4:0]  wr_address,
  input  logic [15:0] wr_value,
  output logic [5:0]  pins,
  output logic [15:0] ctl_reg
);
  import pms_pkg::*;
  // Lines move just after the edge, unrelated to any host access
  always @(posedge sys_clk)
  begin
    pins <= pin_cmd;
    if (wr_strobe && wr_address == PHY_CONTROL_ONE)
      ctl_reg <= wr_value;
  end
endmodule : pms_phy_model

// >>> tb/pms_props.sv
// Checker: port-level properties of the PHY management block
`timescale 1ns/10ps
module pms_props #(
  parameter int unsigned CYCLE_CLKS = 8
) (
  input logic        sys_clk,
  input logic        rst_n,
  input logic        reg_write_strobe,
  input logic [3:0]  reg_select,
  input logic [7:0]  reg_write_data,
  input logic [7:0]  reg_read_data,
  input logic        phy_write_strobe,
  input logic [4:0]  phy_write_address,
  input logic [15:0] phy_write_value,
  input logic        full_duplex_mode
);
  import pms_pkg::*;
  // Completion may land on the counted edge or one later
  localparam int LAT_LO = CYCLE_CLKS;
  localparam int LAT_HI = CYCLE_CLKS + 1;
  logic [4:0] adr_reg;
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of host writes, the word the write must carry
  always_ff @(posedge sys_clk)
  begin
    if (reg_write_strobe && reg_select == REG_PHY_REG_ADDRESS)
      adr_reg <= reg_write_data[4:0];
    if (reg_write_strobe && reg_select == REG_WRITE_DATA_LOW)
      lo_reg <= reg_write_data;
    if (reg_write_strobe && reg_select == REG_WRITE_DATA_HIGH)
      hi_reg <= reg_write_data;
  end
  sequence s_high_write;
    reg_write_strobe && reg_select == REG_WRITE_DATA_HIGH;
  endsequence
  sequence s_read_cmd;
    reg_write_strobe && reg_select == REG_MGMT_COMMAND && reg_write_data[CMD_SINGLE_READ_BIT];
  endsequence
  a_write_launch: assert property (s_high_write |-> ##[LAT_LO:LAT_HI] phy_write_strobe)
    else $error("write pulse late or missing");
  a_write_single: assert property (phy_write_strobe |=> !phy_write_strobe)
    else $error("write pulse too long");
  a_write_word: assert property (phy_write_strobe |-> phy_write_value == {hi_reg, lo_reg})
    else $error("write word wrong");
  a_write_target: assert property (phy_write_strobe |-> phy_write_address == adr_reg)
    else $error("write address wrong");
  a_write_busy: assert property (s_high_write ##2 reg_select == REG_MGMT_STATUS |=>
    reg_read_data[ST_BUSY_BIT]) else $error("busy missing in write");
  a_read_busy: assert property (s_read_cmd ##2 reg_select == REG_MGMT_STATUS |=>
    reg_read_data[ST_BUSY_BIT] && reg_read_data[ST_DATA_NOT_VALID_BIT]) else $error("read flags wrong");
  a_status_spare: assert property (reg_select == REG_MGMT_STATUS |=>
    reg_read_data[7:3] == 5'h00) else $error("status spare bits set");
  a_cmd_spare: assert property (reg_select == REG_MGMT_COMMAND |=>
    reg_read_data[7:2] == 6'h00) else $error("command spare bits set");
  a_silicon_rev: assert property (reg_select == REG_SILICON_REVISION |=>
    reg_read_data == {3'h0, SILICON_REV_VALUE}) else $error("silicon revision wrong");
  a_scan_busy: assert property (reg_select == REG_MGMT_STATUS |=>
    !reg_read_data[ST_SCAN_BIT] || reg_read_data[ST_BUSY_BIT]) else $error("scan without busy");
  a_duplex_follow: assert property (phy_write_strobe && phy_write_address == PHY_CONTROL_ONE
    |-> ##[1:2] full_duplex_mode == hi_reg[0]) else $error("duplex not following");
endmodule : pms_props

// >>> tb/testbench.sv
// Testbench: register-level scenarios against a bench model
`timescale 1ns/10ps
module testbench;
  import pms_pkg::*;
  localparam int unsigned CYC = 8;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_write_strobe = 1'b0;
  logic        reg_read_strobe = 1'b0;
  logic [3:0]  reg_select = 4'h0;
  logic [7:0]  reg_write_data = 8'h00;
  logic [7:0]  reg_read_data;
  logic [5:0]  pin_cmd = 6'h00;
  logic        strap = 1'b1;
  logic [5:0]  pins;
  logic        phy_write_strobe;
  logic [4:0]  phy_write_address;
  logic [15:0] phy_write_value;
  logic        full_duplex_mode;
  logic [15:0] ctl_reg;
  logic [7:0]  b;
  logic [7:0]  c;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic [15:0] wq[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  pms_phy_mgmt_status #(.CYCLE_CLKS(CYC)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_write_strobe(reg_write_strobe), .reg_read_strobe(reg_read_strobe),
    .reg_select(reg_select), .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
    .link_up_pin(pins[0]), .jabber_pin(pins[1]), .transmitting_pin(pins[2]),
    .receiving_pin(pins[3]), .collision_pin(pins[4]), .polarity_reversed_pin(pins[5]),
    .second_led_pin(strap), .phy_write_strobe(phy_write_strobe),
    .phy_write_address(phy_write_address), .phy_write_value(phy_write_value),
    .full_duplex_mode(full_duplex_mode));
  pms_phy_model phy (.sys_clk(sys_clk), .pin_cmd(pin_cmd), .wr_strobe(phy_write_strobe),
    .wr_address(phy_write_address), .wr_value(phy_write_value), .pins(pins),
    .ctl_reg(ctl_reg));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      final_report;
    end
  end
  task final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge sys_clk);
    reg_write_strobe = 1'b1;
    reg_select = s;
    reg_write_data = d;
    @(negedge sys_clk);
    reg_write_strobe = 1'b0;
  endtask : wr
  task rd(input logic [3:0] s, output logic [7:0] d);
    @(negedge sys_clk);
    reg_select = s;
    reg_read_strobe = 1'b1;
    @(negedge sys_clk);
    reg_read_strobe = 1'b0;
    d = reg_read_data;
  endtask : rd
  // Bounded poll; a hang shows up as busy still set at the caller
  task wait_idle(output logic [7:0] s);
    int n;
    n = 0;
    s = 8'h01;
    while (s[ST_BUSY_BIT] !== 1'b0 && n < 200)
    begin
      rd(REG_MGMT_STATUS, s);
      n++;
    end
  endtask : wait_idle
  task phy_read(input logic [4:0] a, input logic [15:0] e);
    logic [7:0] l;
    logic [7:0] h;
    wr(REG_PHY_REG_ADDRESS, {3'h0, a});
    wr(REG_MGMT_COMMAND, 8'h01);
    rd(REG_MGMT_STATUS, l);
    chk({8'h00, l}, 16'h0005);
    wait_idle(l);
    chk({8'h00, l}, 16'h0000);
    rd(REG_READ_DATA_LOW, l);
    rd(REG_READ_DATA_HIGH, h);
    chk({h, l}, e);
  endtask : phy_read
  function automatic logic [15:0] live(input logic [5:0] p, input logic d);
    return {2'b00, p[2], p[3], p[4], p[0], d, 3'b000, p[5], 5'h00};
  endfunction : live
  initial
  begin
    void'($urandom(93919));
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(REG_MGMT_COMMAND, b);
    chk({8'h00, b}, {8'h00, MGMT_COMMAND_RESET});
    rd(REG_SILICON_REVISION, b);
    chk({8'h00, b}, {11'h000, SILICON_REV_VALUE});
    chk({15'h0000, full_duplex_mode}, {15'h0000, strap});
    lo = 8'($urandom);
    hi = 8'($urandom) & 8'hFE;
    wq.push_back({hi, lo});
    wr(REG_PHY_REG_ADDRESS, 8'h00);
    wr(REG_WRITE_DATA_LOW, lo);
    wr(REG_WRITE_DATA_HIGH, hi);
    rd(REG_MGMT_STATUS, b);
    chk({15'h0000, b[ST_BUSY_BIT]}, 16'h0001);
    wait_idle(b);
    chk(ctl_reg, wq.pop_front());
    chk({15'h0000, full_duplex_mode}, {15'h0000, hi[0]});
    phy_read(PHY_IDENT_HIGH, IDENT_HIGH_VALUE);
    phy_read(PHY_IDENT_LOW, {IDENT_LOW_OUI_BITS, PART_NUMBER_VALUE, REVISION_VALUE});
    repeat (4)
    begin
      pin_cmd = 6'($urandom);
      repeat (10) @(negedge sys_clk);
      phy_read(PHY_LIVE_STATUS, live(pin_cmd, hi[0]));
    end
    pin_cmd = 6'h02;
    repeat (10) @(negedge sys_clk);
    pin_cmd = 6'h00;
    repeat (10) @(negedge sys_clk);
    phy_read(PHY_LATCHED_STATUS, 16'h1802);
    pin_cmd = 6'h01;
    repeat (10) @(negedge sys_clk);
    phy_read(PHY_LATCHED_STATUS, 16'h1800);
    phy_read(PHY_LATCHED_STATUS, 16'h1804);
    wr(REG_PHY_REG_ADDRESS, {3'h0, PHY_LIVE_STATUS});
    wr(REG_MGMT_COMMAND, 8'hFE); // No high-byte write or single read while scanning
    repeat (2 * CYC + 10) @(negedge sys_clk);
    rd(REG_MGMT_COMMAND, b);
    chk({8'h00, b}, 16'h0002);
    rd(REG_MGMT_STATUS, b);
    chk({8'h00, b}, 16'h0003);
    pin_cmd = 6'($urandom);
    repeat (2 * CYC + 10) @(negedge sys_clk);
    rd(REG_READ_DATA_LOW, b);
    rd(REG_READ_DATA_HIGH, c);
    chk({c, b}, live(pin_cmd, hi[0]));
    wr(REG_MGMT_COMMAND, 8'h00);
    wait_idle(b);
    chk({8'h00, b}, 16'h0000);
    final_report;
  end
endmodule : testbench
bind pms_phy_mgmt_status pms_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (.*);
